// ---- logic/acqs2_status_top.sv ----
`timescale 1ns/10ps
`include "acqs2_params.svh"
module acqs2_status_top (
    input  wire logic                  clk_sys_i,
    input  wire logic                  nrst_i,
    input  wire logic                  fifo_half_full_n_i,
    input  wire logic                  counter_a1_output_i,
    input  wire logic                  eeprom_serial_out_i,
    input  wire logic [31:0]           s_axi_awaddr_i,
    input  wire logic                  s_axi_awvalid_i,
    output logic                       s_axi_awready_o,
    input  wire logic [31:0]           s_axi_wdata_i,
    input  wire logic [3:0]            s_axi_wstrb_i,
    input  wire logic                  s_axi_wvalid_i,
    output logic                       s_axi_wready_o,
    output acqs2_pkg::acqs2_resp_t     s_axi_bresp_o,
    output logic                       s_axi_bvalid_o,
    input  wire logic                  s_axi_bready_i,
    input  wire logic [31:0]           s_axi_araddr_i,
    input  wire logic                  s_axi_arvalid_i,
    output logic                       s_axi_arready_o,
    output acqs2_pkg::acqs2_word_t     s_axi_rdata_o,
    output acqs2_pkg::acqs2_resp_t     s_axi_rresp_o,
    output logic                       s_axi_rvalid_o,
    input  wire logic                  s_axi_rready_i
);
    import acqs2_pkg::*;

    // =================================================================
    // status sampling
    logic [2:0]    live_bits;
    logic [2:0]    status_bits;
    acqs2_status_t status_word;

    assign live_bits[`ACQS2_BIT_HALF_FULL_N] = fifo_half_full_n_i;
    assign live_bits[`ACQS2_BIT_CNT_A1]      = counter_a1_output_i;
    assign live_bits[`ACQS2_BIT_EEPROM]      = eeprom_serial_out_i;

    acqs2_sync_status #(
        .WIDTH (3)
    ) u_sample (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .d_i       (live_bits),
        .q_o       (status_bits)
    );

    // don't-care bits read as zero
    assign status_word = {5'h00, status_bits};

    // =================================================================
    // read channel
    acqs2_bus_if rd_bus ();
    logic        ar_take;
    logic        r_done;
    logic        rvalid_reg;
    logic        rvalid_next;
    logic        arready_reg;
    logic        arready_next;
    acqs2_word_t rdata_reg;
    acqs2_word_t rdata_next;
    acqs2_resp_t rresp_reg;
    acqs2_resp_t rresp_next;
    acqs2_word_t read_word;
    acqs2_word_t hit_word;
    acqs2_resp_t hit_resp;

    // a read counts only on the edge where arvalid meets arready
    assign ar_take     = s_axi_arvalid_i && arready_reg;
    assign r_done      = rvalid_reg && s_axi_rready_i;
    assign rd_bus.req  = ar_take;
    assign rd_bus.addr = s_axi_araddr_i[`ACQS2_ADDR_W-1:0];

    // upper address bits are not decoded, so the map repeats every 1 kbyte
    acqs2_addr_dec u_rd_dec (
        .bus (rd_bus.dec)
    );

    // status in the low byte; an unmapped address reads zero with slverr
    assign read_word = {24'h000000, status_word};
    assign hit_word  = rd_bus.hit ? read_word : `ACQS2_DATA_ZERO;
    assign hit_resp  = rd_bus.hit ? `ACQS2_RESP_OKAY : `ACQS2_RESP_SLVERR;

    // answer loads on take and stands until the rready edge
    assign rvalid_next  = ar_take ? 1'b1 : (r_done ? 1'b0 : rvalid_reg);
    assign rdata_next   = ar_take ? hit_word : rdata_reg;
    assign rresp_next   = ar_take ? hit_resp : rresp_reg;
    // one read in flight: arready stays low while an answer pends
    assign arready_next = !rvalid_next;

    // answer and ready registers; ready rises on the first edge after reset
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b0;
            rdata_reg   <= `ACQS2_DATA_ZERO;
            rresp_reg   <= `ACQS2_RESP_OKAY;
        end else begin
            rvalid_reg  <= rvalid_next;
            arready_reg <= arready_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    // =================================================================
    // write channel: nothing here is writable, every write gets slverr
    logic        aw_seen_reg;
    logic        aw_seen_next;
    logic        w_seen_reg;
    logic        w_seen_next;
    logic        awready_reg;
    logic        awready_next;
    logic        wready_reg;
    logic        wready_next;
    logic        bvalid_reg;
    logic        bvalid_next;
    acqs2_resp_t bresp_reg;
    acqs2_resp_t bresp_next;
    logic        aw_take;
    logic        w_take;
    logic        aw_have;
    logic        w_have;
    logic        wr_fire;
    logic        b_done;

    // each half is taken on its own valid/ready edge, in either order
    assign aw_take = s_axi_awvalid_i && awready_reg;
    assign w_take  = s_axi_wvalid_i && wready_reg;
    assign aw_have = aw_seen_reg || aw_take;
    assign w_have  = w_seen_reg || w_take;
    assign wr_fire = aw_have && w_have && !bvalid_reg;
    assign b_done  = bvalid_reg && s_axi_bready_i;

    // a held half waits for its partner; both are dropped once answered
    assign aw_seen_next = wr_fire ? 1'b0 : aw_have;
    assign w_seen_next  = wr_fire ? 1'b0 : w_have;
    assign bvalid_next  = wr_fire ? 1'b1 : (b_done ? 1'b0 : bvalid_reg);
    assign bresp_next   = wr_fire ? `ACQS2_RESP_SLVERR : bresp_reg;

    // readys look one edge ahead so that the pins come straight from flops
    assign awready_next = !aw_seen_next && !bvalid_next;
    assign wready_next  = !w_seen_next && !bvalid_next;

    // write address, data and strobes are never stored: the write is dropped
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_seen_reg <= 1'b0;
            w_seen_reg  <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `ACQS2_RESP_OKAY;
        end else begin
            aw_seen_reg <= aw_seen_next;
            w_seen_reg  <= w_seen_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
        end
    end

    // =================================================================
    // outputs, all straight from flops
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rdata_o   = rdata_reg;
    assign s_axi_rresp_o   = rresp_reg;
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o  = wready_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;

    // =================================================================
    // checks: sampled status bits
    // the sampling flop shows its reset value for one edge after release,
    // so each check waits for an edge that was itself out of reset
    // flag level lands in bit 2 one edge later
    a_half_full_bit: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $past(nrst_i) |-> status_word[`ACQS2_BIT_HALF_FULL_N] == $past(fifo_half_full_n_i))
        else $error("half-full bit does not follow fifo flag");

    // below half full reads high
    a_below_half: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $past(nrst_i) && $past(fifo_half_full_n_i) |-> status_word[`ACQS2_BIT_HALF_FULL_N])
        else $error("half-full bit low while fifo below half");

    // counter output lands in bit 1
    a_counter_bit: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $past(nrst_i) |-> status_word[`ACQS2_BIT_CNT_A1] == $past(counter_a1_output_i))
        else $error("counter bit does not follow counter output");

    // eeprom data lands in bit 0
    a_eeprom_bit: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $past(nrst_i) |-> status_word[`ACQS2_BIT_EEPROM] == $past(eeprom_serial_out_i))
        else $error("eeprom bit does not follow serial output");

    // =================================================================
    // checks: read channel
    // a mapped read answers with the status seen at the take edge
    a_read_answer: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ar_take && rd_bus.hit |=> s_axi_rvalid_o && s_axi_rresp_o == `ACQS2_RESP_OKAY
        && s_axi_rdata_o[7:0] == $past(status_word))
        else $error("status read returned wrong data");

    // an unmapped read is refused with zero data
    a_unmapped_read: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ar_take && !rd_bus.hit |=> s_axi_rvalid_o && s_axi_rresp_o == `ACQS2_RESP_SLVERR
        && s_axi_rdata_o == `ACQS2_DATA_ZERO)
        else $error("unmapped read not refused");

    // don't-care bits and the upper word read zero
    a_upper_zero: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_axi_rvalid_o |-> s_axi_rdata_o[31:3] == 29'h0)
        else $error("upper read bits not zero");

    // a pending answer stands until rready
    a_r_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read answer dropped before accept");

    // the response code stands with the data
    a_rresp_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_axi_rvalid_o && !s_axi_rready_i |=> $stable(s_axi_rresp_o))
        else $error("read response changed before accept");

    // no second read is taken while one is answered
    a_ar_blocked: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read accepted while answer pending");

    // the answer leaves right after the rready edge
    a_read_leaves: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        r_done |=> !s_axi_rvalid_o)
        else $error("read answer stayed after accept");

    // read data moves only when a read is taken
    a_rdata_only_take: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !ar_take |=> $stable(s_axi_rdata_o))
        else $error("read data changed without a read");

    // =================================================================
    // checks: write channel
    // every write answer is a refusal
    a_write_refused: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_axi_bvalid_o |-> s_axi_bresp_o == `ACQS2_RESP_SLVERR)
        else $error("write to read-only register not refused");

    // both halves in hand give an answer on the next edge
    a_write_answer: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        wr_fire |=> s_axi_bvalid_o)
        else $error("write not answered");

    // the write answer stands until bready
    a_b_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write answer dropped before accept");

    // no new write half is taken while an answer pends
    a_aw_blocked: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write accepted while answer pending");

    // a held address waits for its data
    a_aw_half_held: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        aw_seen_reg && !wr_fire |=> aw_seen_reg)
        else $error("held write address lost");

    // held data waits for its address
    a_w_half_held: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        w_seen_reg && !wr_fire |=> w_seen_reg)
        else $error("held write data lost");

    // =================================================================
    // covers
    // status register read
    c_status_read: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ar_take && rd_bus.hit);

    // unmapped read
    c_bad_read: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ar_take && !rd_bus.hit);

    // refused write answered
    c_write: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_axi_bvalid_o && s_axi_bready_i);

    // address taken on an edge without data, whether data is still to come or already held
    c_write_split: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        aw_take && !w_take);

    // read taken while the fifo is at least half full
    c_half_full_read: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ar_take && rd_bus.hit && !status_word[`ACQS2_BIT_HALF_FULL_N]);
endmodule : acqs2_status_top

// ---- logic/acqs2_params.svh ----
`ifndef ACQS2_PARAMS_SVH
`define ACQS2_PARAMS_SVH

// register map (printed offset 1d is not a multiple of four: index times four)
`define ACQS2_IDX_STATUS_TWO   8'h1d
`define ACQS2_ADDR_STATUS_TWO  10'h074
`define ACQS2_ADDR_W           10
// field positions
`define ACQS2_BIT_HALF_FULL_N  2
`define ACQS2_BIT_CNT_A1       1
`define ACQS2_BIT_EEPROM       0
// reset values
`define ACQS2_RST_STATUS       8'h07
`define ACQS2_DATA_ZERO        32'h0000_0000
// responses
`define ACQS2_RESP_OKAY        2'h0
`define ACQS2_RESP_SLVERR      2'h2

`endif

// ---- logic/acqs2_pkg.sv ----
package acqs2_pkg;
    typedef logic [7:0]  acqs2_status_t;
    typedef logic [31:0] acqs2_word_t;
    typedef logic [1:0]  acqs2_resp_t;
endpackage : acqs2_pkg

// ---- logic/acqs2_bus_if.sv ----
`timescale 1ns/10ps
// carries one read request and its answer between the address decoder and the top
interface acqs2_bus_if;
    logic       req;
    logic [9:0] addr;
    logic       hit;
    modport dec (input req, input addr, output hit);
    modport top (output req, output addr, input hit);
endinterface : acqs2_bus_if

// ---- logic/acqs2_addr_dec.sv ----
`timescale 1ns/10ps
`include "acqs2_params.svh"
// =====================================================================
// address decode
module acqs2_addr_dec (
    acqs2_bus_if.dec bus
);
    import acqs2_pkg::*;
    // aligned word match only
    assign bus.hit = bus.req && (bus.addr == `ACQS2_ADDR_STATUS_TWO);
endmodule : acqs2_addr_dec

// ---- logic/acqs2_sync_status.sv ----
`timescale 1ns/10ps
`include "acqs2_params.svh"
// =====================================================================
// status sampler: one register stage, inputs already synchronous
module acqs2_sync_status #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk_sys_i,
    input  wire logic             nrst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    import acqs2_pkg::*;
    // refuse a width that the reset value cannot fill
    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
        $error("acqs2_sync_status: WIDTH must be 1 to 8");
    end
    // sample live levels every cycle
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_o <= WIDTH'(`ACQS2_RST_STATUS);
        end else begin
            q_o <= d_i;
        end
    end
endmodule : acqs2_sync_status

// ---- bench/acqs2_pin_model.sv ----
`timescale 1ns/10ps
// =====================================================
// far side: fifo flag, counter a1 and eeprom data line
module acqs2_pin_model (
    input  wire logic       clk_sys_i,
    input  wire logic [2:0] val_i,
    output logic            fifo_half_full_n_o,
    output logic            counter_a1_output_o,
    output logic            eeprom_serial_out_o
);
    // levels move only just after an edge, like the real sources
    always_ff @(posedge clk_sys_i) begin
        {fifo_half_full_n_o, counter_a1_output_o, eeprom_serial_out_o} <= val_i;
    end
endmodule : acqs2_pin_model

// ---- bench/tb_acq_status_register_two.sv ----
`timescale 1ns/10ps
`include "acqs2_params.svh"
module tb_acq_status_register_two;
    import acqs2_pkg::*;
    logic        clk_sys_i, nrst_i, awv, wv, bv, brdy, arv, arr, awr, wr_r, rv, rrdy;
    logic        ff_n, cnt, eep;
    logic [31:0] awa, wd, ara, rnd;
    logic [3:0]  ws;
    logic [2:0]  pins;
    acqs2_word_t rd_d;
    acqs2_resp_t br, rr;
    logic [33:0] rq[$];
    acqs2_resp_t bq[$];
    int          fails, n_compared;
    localparam logic [31:0] ADDR = {22'h0, `ACQS2_ADDR_STATUS_TWO};

    acqs2_pin_model acqs2_pin_model_i (.clk_sys_i(clk_sys_i), .val_i(pins),
        .fifo_half_full_n_o(ff_n), .counter_a1_output_o(cnt), .eeprom_serial_out_o(eep));
    acqs2_status_top acqs2_status_top_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .fifo_half_full_n_i(ff_n), .counter_a1_output_i(cnt), .eeprom_serial_out_i(eep),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r),
        .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rd_d), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy));

    // =====================================================
    // shared tasks
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic cmp_word(input acqs2_word_t got, input acqs2_word_t exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_resp(input acqs2_resp_t got, input acqs2_resp_t exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_resp
    // ready is looked at mid-cycle, so the edge that follows is the handshake
    task automatic rd(input logic [31:0] a, input acqs2_word_t ed, input acqs2_resp_t er);
        rq.push_back({ed, er});
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do @(negedge clk_sys_i); while (arr !== 1'b1);
        @(posedge clk_sys_i);
        arv <= 1'b0;
        do @(negedge clk_sys_i); while (rv !== 1'b1);
        // rready stays up: a following read may start in this very step
        @(posedge clk_sys_i);
    endtask : rd
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input acqs2_resp_t er);
        logic pa, pw, ta, tw;
        bq.push_back(er);
        {awa, wd, ws} <= {a, d, 4'hf};
        {awv, wv, brdy} <= 3'b111;
        {pa, pw} = 2'b11;
        while (pa || pw) begin
            @(negedge clk_sys_i);
            ta = pa && awr === 1'b1;
            tw = pw && wr_r === 1'b1;
            @(posedge clk_sys_i);
            if (ta) begin
                awv <= 1'b0;
                pa = 1'b0;
            end
            if (tw) begin
                wv <= 1'b0;
                pw = 1'b0;
            end
        end
        // bready stays up, like rready in rd
        do @(negedge clk_sys_i); while (bv !== 1'b1);
        @(posedge clk_sys_i);
    endtask : wr
    // pins settle through the model and the sampling flop before the read
    task automatic chk(input logic [2:0] v);
        pins <= v;
        repeat (3) @(posedge clk_sys_i);
        rd(ADDR, {29'h0, v}, `ACQS2_RESP_OKAY);
    endtask : chk
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // =====================================================
    // clock, watchdog, monitor and main sequence
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        fails++;
        tally_and_finish();
    end
    // answers are taken at the next edge, so mid-cycle sees each once
    always @(negedge clk_sys_i) begin
        if (rv === 1'b1 && rrdy === 1'b1) begin
            cmp_word(rd_d, rq[0][33:2]);
            cmp_resp(rr, rq[0][1:0]);
            void'(rq.pop_front());
        end
        if (bv === 1'b1 && brdy === 1'b1) cmp_resp(br, bq.pop_front());
    end
    initial begin
        {nrst_i, awv, wv, brdy, arv, rrdy, pins, ws} = '0;
        {awa, wd, ara} = '0;
        rnd = 32'h8b84a4b7;
        {fails, n_compared} = '0;
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        for (int i = 0; i < 8; i++) chk(i[2:0]);
        $display("test pin walk done");
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            chk(rnd[2:0]);
            rd((rnd[9:2] == 8'h1d) ? 32'h70 : {22'h0, rnd[9:2], 2'b00}, '0,
                `ACQS2_RESP_SLVERR);
        end
        $display("test random pins and unmapped reads done");
        wr(ADDR, ~rnd, `ACQS2_RESP_SLVERR);
        rd(ADDR, {29'h0, rnd[2:0]}, `ACQS2_RESP_OKAY);
        $display("test write refused done");
        tally_and_finish();
    end
endmodule : tb_acq_status_register_two
